// >>> rtl/dmcp_defines.svh
`ifndef DMCP_DEFINES_SVH
`define DMCP_DEFINES_SVH

// Physical address split
`define DMCP_ADDR_W 22
`define DMCP_BYTE_BIT 0
`define DMCP_INDEX_LSB 1
`define DMCP_INDEX_MSB 12
`define DMCP_LABEL_LSB 13
`define DMCP_LABEL_MSB 21
`define DMCP_INDEX_W 12
`define DMCP_LABEL_W 9
`define DMCP_TAG_W 12
`define DMCP_BYTE_W 8
`define DMCP_WORD_W 16

// Tag entry layout
`define DMCP_TAG_LABEL_LSB 0
`define DMCP_TAG_LABEL_MSB 8
`define DMCP_TAG_VALID_BIT 9
`define DMCP_TAG_PARITY_BIT_BIT 10
`define DMCP_TAG_SPARE_BIT 11

// Word and parity layout
`define DMCP_LOW_LSB 0
`define DMCP_LOW_MSB 7
`define DMCP_HIGH_LSB 8
`define DMCP_HIGH_MSB 15
`define DMCP_PAR_LOW_BIT 0
`define DMCP_PAR_HIGH_BIT 1
`define DMCP_PAR_W 2

`endif

// >>> rtl/dmcp_pkg.sv
package dmcp_pkg;
	`include "dmcp_defines.svh"

	typedef struct packed {
		logic [`DMCP_ADDR_W-1:0] addr;
		logic low_byte_select_n;
		logic high_byte_select_n;
		logic tag_select_n;
		logic ram_write_n;
		logic update_n;
	} dmcp_ctrl_type;

	typedef struct packed {
		logic force_bad_parity;
		logic expected_tag_parity;
		logic [`DMCP_LABEL_W-1:0] tag_label;
		logic tag_valid;
	} dmcp_path_type;

	typedef struct packed {
		logic [`DMCP_WORD_W-1:0] word;
		logic [`DMCP_BYTE_W-1:0] byte_data;
		logic [`DMCP_TAG_W-1:0] tag_entry;
		logic [1:0] byte_parity_good_n;
		logic [1:0] comp_n;
		logic tag_parity_mismatch;
		logic miss_n;
		logic comp_hit_n;
	} dmcp_resp_type;
endpackage

// >>> rtl/dmcp_ram.sv
`timescale 1ns/1ps
module dmcp_ram #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Access port
	input wire logic [AW-1:0] addr_in,
	input wire logic sel_in,
	input wire logic we_in,
	input wire logic [DW-1:0] wdata_in,
	output logic [DW-1:0] rdata_out
);
	typedef struct packed {
		logic [DW-1:0] rdata;
	} dmcp_ram_state_type;

	logic [DW-1:0] mem_r [0:(1<<AW)-1];
	dmcp_ram_state_type st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (sel_in && !we_in) begin
			st_nxt.rdata = mem_r[addr_in];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sel_in && we_in) begin
			mem_r[addr_in] <= wdata_in;
		end
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_out = st_r.rdata;
endmodule // dmcp_ram

// >>> rtl/dmcp_cache.sv
// What this block does
// RQ1 - Byte bit picks high or low byte
// RQ2 - Index bits 12:1 address data store
// RQ3 - Data valid only after label confirmed
// RQ4 - Low byte read on select, written with enable
// RQ5 - High byte read on select, written with enable
// RQ6 - Low even, high odd, separate write and read parity trees
// RQ7 - Parity generated only during fill update
// RQ8 - Force bad parity inverts stored parity
// RQ9 - Read checks parity, good output low
// RQ10 - Parity store follows data selects
// RQ11 - Tag store holds label, valid, parity
// RQ12 - Tag read on select, written with enable
// RQ13 - Tag parity stored as even parity
// RQ14 - Comparator low on valid label match
// RQ15 - Tag parity XOR low when agreeing
// RQ16 - Hit only when all five checks low
// RQ17 - Identical hit to processor and sequencer
// RQ18 - Path predicts tag parity like stored
// RQ19 - Path forces bad parity from control bit
// RQ20 - Sequencer selects both bytes for words
`timescale 1ns/1ps
`include "dmcp_defines.svh"
module dmcp_cache (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Sequencer and address
	input wire dmcp_pkg::dmcp_ctrl_type ctrl_in,
	// Cache data path
	input wire dmcp_pkg::dmcp_path_type path_in,
	// Processor data write
	input wire logic [`DMCP_WORD_W-1:0] wdata_in,
	// Answers
	output dmcp_pkg::dmcp_resp_type resp_out,
	output logic hit_cpu_out,
	output logic hit_seq_out
);
	import dmcp_pkg::*;

	typedef struct packed {
		logic read_pend;
		logic byte_sel;
		logic [`DMCP_LABEL_W-1:0] label;
		logic low_sel;
		logic high_sel;
		logic [`DMCP_WORD_W-1:0] word;
		logic [`DMCP_BYTE_W-1:0] byte_data;
		logic [1:0] par_good_n;
		logic [1:0] comp_n;
		logic tag_mis;
		logic [`DMCP_TAG_W-1:0] tag;
		logic hit;
	} dmcp_state_type;

	dmcp_state_type st_r, st_nxt;

	logic [`DMCP_INDEX_W-1:0] index;
	logic low_sel, high_sel, tag_sel, we;
	logic [1:0] sel;
	logic [`DMCP_WORD_W-1:0] rword;
	logic [`DMCP_PAR_W-1:0] par_wr, par_rd;
	logic [`DMCP_TAG_W-1:0] tag_wr, tag_rd;
	logic even_low, odd_high;

	// RQ2 index addressing
	assign index = ctrl_in.addr[`DMCP_INDEX_MSB:`DMCP_INDEX_LSB];
	assign low_sel = !ctrl_in.low_byte_select_n;
	assign high_sel = !ctrl_in.high_byte_select_n;
	assign tag_sel = !ctrl_in.tag_select_n;
	assign we = !ctrl_in.ram_write_n;
	assign sel = {high_sel, low_sel};

	// RQ6 write side parity trees
	assign even_low = ^wdata_in[`DMCP_LOW_MSB:`DMCP_LOW_LSB];
	assign odd_high = ~^wdata_in[`DMCP_HIGH_MSB:`DMCP_HIGH_LSB];

	// RQ7 RQ8 generate then invert
	always_comb begin
		par_wr = '0;
		if (!ctrl_in.update_n) begin
			par_wr[`DMCP_PAR_LOW_BIT] = even_low ^ path_in.force_bad_parity;
			par_wr[`DMCP_PAR_HIGH_BIT] = odd_high ^ path_in.force_bad_parity;
		end
	end

	// RQ11 RQ13 tag entry build
	always_comb begin
		tag_wr = '0;
		tag_wr[`DMCP_TAG_LABEL_MSB:`DMCP_TAG_LABEL_LSB] = path_in.tag_label;
		tag_wr[`DMCP_TAG_VALID_BIT] = path_in.tag_valid;
		tag_wr[`DMCP_TAG_PARITY_BIT_BIT] = ^path_in.tag_label;
	end

	// RQ4 RQ5 RQ10 per byte stores
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_byte
			dmcp_ram #(.AW(`DMCP_INDEX_W), .DW(`DMCP_BYTE_W)) u_data (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.addr_in(index),
				.sel_in(sel[g]),
				.we_in(we),
				.wdata_in(wdata_in[g*`DMCP_BYTE_W +: `DMCP_BYTE_W]),
				.rdata_out(rword[g*`DMCP_BYTE_W +: `DMCP_BYTE_W])
			);
			dmcp_ram #(.AW(`DMCP_INDEX_W), .DW(1)) u_par (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.addr_in(index),
				.sel_in(sel[g]),
				.we_in(we),
				.wdata_in(par_wr[g]),
				.rdata_out(par_rd[g])
			);
		end
	endgenerate

	// RQ12 tag store access
	dmcp_ram #(.AW(`DMCP_INDEX_W), .DW(`DMCP_TAG_W)) u_tag (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.addr_in(index),
		.sel_in(tag_sel),
		.we_in(we),
		.wdata_in(tag_wr),
		.rdata_out(tag_rd)
	);

	always_comb begin
		logic lpar, hpar;
		logic lbad, hbad, lab_ok;
		st_nxt = st_r;
		lpar = ^rword[`DMCP_LOW_MSB:`DMCP_LOW_LSB];
		hpar = ~^rword[`DMCP_HIGH_MSB:`DMCP_HIGH_LSB];
		lbad = lpar ^ par_rd[`DMCP_PAR_LOW_BIT];
		hbad = hpar ^ par_rd[`DMCP_PAR_HIGH_BIT];
		lab_ok = tag_rd[`DMCP_TAG_VALID_BIT]
			&& (tag_rd[`DMCP_TAG_LABEL_MSB:`DMCP_TAG_LABEL_LSB] == st_r.label);
		// Capture address for the pending read
		st_nxt.read_pend = (low_sel || high_sel || tag_sel) && !we && ctrl_in.update_n;
		st_nxt.byte_sel = ctrl_in.addr[`DMCP_BYTE_BIT];
		st_nxt.label = ctrl_in.addr[`DMCP_LABEL_MSB:`DMCP_LABEL_LSB];
		st_nxt.low_sel = low_sel;
		st_nxt.high_sel = high_sel;
		st_nxt.hit = 1'b0;
		if (st_r.read_pend) begin
			st_nxt.word = rword;
			st_nxt.tag = tag_rd;
			// RQ1 byte steering
			st_nxt.byte_data = st_r.byte_sel ? rword[`DMCP_HIGH_MSB:`DMCP_HIGH_LSB]
				: rword[`DMCP_LOW_MSB:`DMCP_LOW_LSB];
			// RQ9 parity check
			st_nxt.par_good_n[0] = st_r.low_sel ? lbad : 1'b0;
			st_nxt.par_good_n[1] = st_r.high_sel ? hbad : 1'b0;
			// RQ14 label comparators
			st_nxt.comp_n = lab_ok ? 2'b00 : 2'b11;
			// RQ15 tag parity compare
			st_nxt.tag_mis = tag_rd[`DMCP_TAG_PARITY_BIT_BIT] ^ path_in.expected_tag_parity;
			// RQ3 RQ16 hit gate
			st_nxt.hit = lab_ok && !(st_r.low_sel && lbad) && !(st_r.high_sel && hbad)
				&& !(tag_rd[`DMCP_TAG_PARITY_BIT_BIT] ^ path_in.expected_tag_parity);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= '0;
			st_r.comp_n <= 2'b11;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		resp_out.word = st_r.word;
		resp_out.byte_data = st_r.byte_data;
		resp_out.tag_entry = st_r.tag;
		resp_out.byte_parity_good_n = st_r.par_good_n;
		resp_out.comp_n = st_r.comp_n;
		resp_out.tag_parity_mismatch = st_r.tag_mis;
		resp_out.miss_n = st_r.hit;
		resp_out.comp_hit_n = st_r.hit;
	end

	// RQ17 twin hit outputs
	assign hit_cpu_out = st_r.hit;
	assign hit_seq_out = st_r.hit;
endmodule // dmcp_cache

// >>> dv/dmcp_path_model.sv
`timescale 1ns/1ps
module dmcp_path_model (
	// Address
	input wire logic [21:0] addr_in,
	// Controls
	input wire logic ctl_bit06_in,
	input wire logic valid_in,
	input wire logic flip_in,
	// Path
	output dmcp_pkg::dmcp_path_type path_out
);
	import dmcp_pkg::*;
	always_comb begin
		path_out.force_bad_parity = ctl_bit06_in;
		path_out.expected_tag_parity = ^addr_in[21:13] ^ flip_in;
		path_out.tag_label = addr_in[21:13];
		path_out.tag_valid = valid_in;
	end
endmodule // dmcp_path_model

// >>> dv/dmcp_cache_checker.sv
`timescale 1ns/1ps
module dmcp_cache_checker (
	// Inputs
	input wire logic clk_in,
	input wire logic rst_in,
	input wire dmcp_pkg::dmcp_ctrl_type ctrl_in,
	input wire dmcp_pkg::dmcp_path_type path_in,
	input wire logic [15:0] wdata_in,
	// Outputs
	input wire dmcp_pkg::dmcp_resp_type resp_out,
	input wire logic hit_cpu_out,
	input wire logic hit_seq_out
);
	import dmcp_pkg::*;
	wire rd = !ctrl_in.tag_select_n && ctrl_in.ram_write_n && ctrl_in.update_n;
	wire clean = resp_out.comp_n == 2'h0 && resp_out.byte_parity_good_n == 2'h0 && !resp_out.tag_parity_mismatch;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_read;
		rd;
	endsequence
	hits_same_a: assert property (hit_seq_out == hit_cpu_out && resp_out.miss_n == hit_cpu_out
		&& resp_out.comp_hit_n == hit_cpu_out) else $error("hit outputs differ");
	hit_read_a: assert property (hit_cpu_out |-> $past(rd, 2)) else $error("hit without read");
	hit_clean_a: assert property (s_read |-> ##2 (hit_cpu_out == clean)) else $error("hit wrong");
	comp_pair_a: assert property (resp_out.comp_n inside {2'h0, 2'h3}) else $error("comp split");
	comp_tag_a: assert property (s_read |-> ##2 (resp_out.comp_n[0] == !(resp_out.tag_entry[9]
		&& resp_out.tag_entry[8:0] == $past(ctrl_in.addr[21:13], 2)))) else $error("comp wrong");
	par_xor_a: assert property (s_read |-> ##2 (resp_out.tag_parity_mismatch ==
		(resp_out.tag_entry[10] ^ $past(path_in.expected_tag_parity)))) else $error("xor wrong");
	tag_even_a: assert property (s_read |-> ##2 (resp_out.tag_entry[10] == ^resp_out.tag_entry[8:0]))
		else $error("tag parity wrong");
	write_nohit_a: assert property (!ctrl_in.ram_write_n |-> ##2 !hit_cpu_out) else $error("hit on write");
endmodule // dmcp_cache_checker
bind dmcp_cache dmcp_cache_checker chk_i (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in(ctrl_in), .path_in(path_in),
	.wdata_in(wdata_in), .resp_out(resp_out), .hit_cpu_out(hit_cpu_out), .hit_seq_out(hit_seq_out));

// >>> dv/tb_direct_mapped_cache_parity_hit.sv
`timescale 1ns/1ps
module tb_direct_mapped_cache_parity_hit;
	import dmcp_pkg::*;
	localparam logic [21:0] adr_a = 22'h2ab64e;
	localparam logic [21:0] adr_b = 22'h0c0102;
	localparam logic [21:0] adr_c = 22'h000204;
	localparam logic [21:0] adr_d = 22'h3fe806;
	logic clk_in = 0;
	logic rst_in = 1;
	logic [21:0] addr = '0;
	logic [4:0] sel = 5'h1f;
	logic [15:0] wdata = '0;
	logic bad = 0;
	logic vld = 1;
	logic flip = 0;
	dmcp_path_type path;
	dmcp_resp_type r;
	logic hc;
	logic hs;
	int n_fail = 0;
	int checks = 0;
	always #10 clk_in = ~clk_in;
	dmcp_path_model pm (.addr_in(addr), .ctl_bit06_in(bad), .valid_in(vld), .flip_in(flip), .path_out(path));
	dmcp_cache dut (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in({addr, sel}), .path_in(path), .wdata_in(wdata),
		.resp_out(r), .hit_cpu_out(hc), .hit_seq_out(hs));
	task automatic results;
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [30:0] g, input logic [30:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic op(input logic [21:0] a, input logic [4:0] s, input logic [15:0] d);
		@(negedge clk_in);
		addr = a;
		sel = s;
		wdata = d;
		@(negedge clk_in);
		sel = 5'h1f;
	endtask
	task automatic rd(input logic [21:0] a, input logic [30:0] e);
		op(a, 5'h03, 16'h0000);
		@(posedge clk_in);
		#1;
		chk({r.word, r.byte_data, r.byte_parity_good_n, r.comp_n, r.tag_parity_mismatch, hc, hs}, e);
	endtask
	task automatic t_hit;
		op(adr_a, 5'h00, 16'h5a3c);
		rd(adr_a | 22'h1, {16'h5a3c, 8'h5a, 5'h00, 2'h3});
	endtask
	task automatic t_label;
		rd(adr_a ^ 22'h2000, {16'h5a3c, 8'h3c, 5'h07, 2'h0});
	endtask
	task automatic t_byte;
		op(adr_a, 5'h0c, 16'hffc3);
		rd(adr_a, {16'h5ac3, 8'hc3, 5'h00, 2'h3});
	endtask
	task automatic t_flip;
		@(negedge clk_in);
		flip = 1;
		rd(adr_a, {16'h5ac3, 8'hc3, 5'h01, 2'h0});
		@(negedge clk_in);
		flip = 0;
	endtask
	task automatic t_force;
		bad = 1;
		op(adr_b, 5'h00, 16'h1234);
		bad = 0;
		rd(adr_b, {16'h1234, 8'h34, 5'h18, 2'h0});
	endtask
	task automatic t_nofill;
		op(adr_c, 5'h01, 16'h0001);
		rd(adr_c, {16'h0001, 8'h01, 5'h18, 2'h0});
	endtask
	task automatic t_inval;
		@(negedge clk_in);
		vld = 0;
		op(adr_d, 5'h00, 16'hffff);
		vld = 1;
		rd(adr_d, {16'hffff, 8'hff, 5'h06, 2'h0});
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		@(negedge clk_in);
		chk({27'h0, r.comp_n, hc, hs}, {27'h0, 4'hc});
		rst_in = 0;
		t_hit;
		t_label;
		t_byte;
		t_flip;
		t_force;
		t_nofill;
		t_inval;
		results;
	end
	initial begin
		repeat (2000) @(posedge clk_in);
		n_fail++;
		results;
	end
endmodule // tb_direct_mapped_cache_parity_hit
